// [core/lsc_status.sv]
`timescale 1ns/10ps
`include "lsc_defs.svh"

module lsc_status (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       spi_sclk,
  input  wire logic                       spi_cs_n,
  input  wire logic                       spi_sdio_in,
  output logic                            spi_sdio_out,
  output logic                            spi_sdio_oe,
  input  wire logic                       skip_initial_alignment,
  input  wire lsc_pkg::lsc_lane_vec_t     symbol_lock_in,
  input  wire lsc_pkg::lsc_lane_vec_t     frame_align_in,
  input  wire lsc_pkg::lsc_lane_vec_t     init_align_in,
  input  wire logic                       cfg_valid,
  output logic                            cfg_ready,
  input  wire logic [2:0]                 cfg_lane,
  input  wire logic [7:0]                 cfg_data,
  input  wire logic                       cfg_last,
  output lsc_pkg::lsc_lane_vec_t          symbol_lock_status,
  output lsc_pkg::lsc_lane_vec_t          frame_align_status,
  output lsc_pkg::lsc_lane_vec_t          lane_checksum_ok,
  output lsc_pkg::lsc_lane_vec_t          initial_lane_align_status
);
  import lsc_pkg::*;

  // ***********************************************************
  // configuration octet stream through the pair buffer
  // ***********************************************************
  logic                        buf_in_ready;
  logic                        buf_valid;
  logic [`LSC_BUF_WIDTH-1:0]   buf_data;
  logic                        settle;
  wire                         buf_take;
  wire  [`LSC_LANE_BITS-1:0]   oct_lane;
  wire  [7:0]                  oct_data;
  wire                         oct_last;

  // a bubble after each closing octet keeps the result update and the
  // next lane's first octet in separate cycles; the buffer absorbs it
  assign buf_take = buf_valid & ~settle;
  assign oct_lane = buf_data[11:9];
  assign oct_data = buf_data[8:1];
  assign oct_last = buf_data[0];
  assign cfg_ready = buf_in_ready;

  lsc_pair_buffer u_pair_buffer (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (cfg_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({cfg_lane, cfg_data, cfg_last}),
    .out_valid (buf_valid),
    .out_ready (~settle),
    .out_data  (buf_data)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      settle <= 1'b0;
    end else begin
      settle <= buf_take & oct_last;
    end
  end

  // ***********************************************************
  // per-lane checksum: sum of octets mod 256 against closing octet
  // ***********************************************************
  generate
    for (genvar g = 0; g < `LSC_LANES; g++) begin : g_lane
      logic [7:0] acc;
      wire        hit;
      wire        sum_match;

      assign hit       = buf_take & (oct_lane == 3'(g));
      assign sum_match = (acc == oct_data);

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          acc                 <= `LSC_ACC_RESET;
          lane_checksum_ok[g] <= 1'b0;
        end else if (~symbol_lock_in[g]) begin
          // losing symbol lock voids any result of that lane
          acc                 <= `LSC_ACC_RESET;
          lane_checksum_ok[g] <= 1'b0;
        end else if (hit & oct_last) begin
          acc <= `LSC_ACC_RESET;
          // no alignment sequence means no configuration data to judge
          if (~skip_initial_alignment) begin
            lane_checksum_ok[g] <= sum_match;
          end
        end else if (hit) begin
          acc <= acc + oct_data;
        end
      end
    end
  endgenerate

  // ***********************************************************
  // live lane status, one register stage
  // ***********************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      symbol_lock_status        <= `LSC_STAT_RESET;
      frame_align_status        <= `LSC_STAT_RESET;
      initial_lane_align_status <= `LSC_STAT_RESET;
    end else begin
      symbol_lock_status        <= symbol_lock_in;
      frame_align_status        <= frame_align_in;
      initial_lane_align_status <= init_align_in;
    end
  end

  // ***********************************************************
  // serial port input synchronisers
  // ***********************************************************
  logic  sclk_s1;
  logic  sclk_s2;
  logic  sclk_s3;
  logic  cs_s1;
  logic  cs_s2;
  logic  sdi_s1;
  logic  sdi_s2;
  wire   sclk_rise;
  wire   sclk_fall;
  wire   selected;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
    end else begin
      sclk_s1 <= spi_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1   <= spi_cs_n;
      cs_s2   <= cs_s1;
      sdi_s1  <= spi_sdio_in;
      sdi_s2  <= sdi_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign selected  = ~cs_s2;

  // ***********************************************************
  // read decode, all registers read-only
  // ***********************************************************
  logic [15:0]  instr_shift;
  wire  [14:0]  instr_addr;
  wire          hit_symbol;
  wire          hit_frame;
  wire          hit_sum;
  wire          hit_init;
  wire  [7:0]   read_data;

  // address is complete on the sixteenth rising edge, so decode the
  // incoming bit directly rather than waiting a cycle
  assign instr_addr = {instr_shift[13:0], sdi_s2};
  assign hit_symbol = (instr_addr == `LSC_ADDR_SYMBOL_LOCK);
  assign hit_frame  = (instr_addr == `LSC_ADDR_FRAME_ALIGN);
  assign hit_sum    = (instr_addr == `LSC_ADDR_CFG_SUM_OK);
  assign hit_init   = (instr_addr == `LSC_ADDR_INIT_ALIGN);
  assign read_data  = hit_symbol ? symbol_lock_status :
                      hit_frame  ? frame_align_status :
                      hit_sum    ? lane_checksum_ok :
                      hit_init   ? initial_lane_align_status :
                      `LSC_UNMAPPED_DATA;

  // ***********************************************************
  // serial frame sequencer
  // ***********************************************************
  lsc_spi_state_t  state;
  logic [4:0]      bit_cnt;
  logic            read_op;
  logic [7:0]      tx_shift;
  wire             instr_done;

  assign instr_done = sclk_rise & (bit_cnt == `LSC_INSTR_LAST);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= LSC_SPI_IDLE;
      bit_cnt      <= `LSC_CNT_ZERO;
      instr_shift  <= 16'h0000;
      read_op      <= 1'b0;
      tx_shift     <= `LSC_STAT_RESET;
      spi_sdio_out <= 1'b0;
      spi_sdio_oe  <= 1'b0;
    end else if (~selected) begin
      state       <= LSC_SPI_IDLE;
      bit_cnt     <= `LSC_CNT_ZERO;
      read_op     <= 1'b0;
      spi_sdio_oe <= 1'b0;
    end else begin
      case (state)
        LSC_SPI_IDLE: begin
          state   <= LSC_SPI_INSTR;
          bit_cnt <= `LSC_CNT_ZERO;
        end
        LSC_SPI_INSTR: begin
          if (sclk_rise) begin
            instr_shift <= {instr_shift[14:0], sdi_s2};
            bit_cnt     <= bit_cnt + `LSC_CNT_ONE;
          end
          if (instr_done) begin
            state    <= LSC_SPI_DATA;
            read_op  <= instr_shift[`LSC_RW_BIT];
            // snapshot only; reading never alters lane state
            tx_shift <= read_data;
          end
        end
        LSC_SPI_DATA: begin
          // write data is clocked through and dropped: nothing is writable
          if (sclk_rise & (bit_cnt != `LSC_FRAME_BITS)) begin
            bit_cnt <= bit_cnt + `LSC_CNT_ONE;
          end
          if (sclk_fall) begin
            if (bit_cnt == `LSC_FRAME_BITS) begin
              spi_sdio_oe <= 1'b0;
            end else if (read_op) begin
              spi_sdio_oe  <= 1'b1;
              spi_sdio_out <= tx_shift[7];
              tx_shift     <= {tx_shift[6:0], 1'b0};
            end
          end
        end
        default: begin
          state <= LSC_SPI_IDLE;
        end
      endcase
    end
  end
endmodule

// [core/lsc_defs.svh]
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// ***********************************************************
// register map (byte addresses on the configuration port)
// ***********************************************************
`define LSC_ADDR_SYMBOL_LOCK  15'h0470
`define LSC_ADDR_FRAME_ALIGN  15'h0471
`define LSC_ADDR_CFG_SUM_OK   15'h0472
`define LSC_ADDR_INIT_ALIGN   15'h0473

// ***********************************************************
// widths, reset values and fixed values
// ***********************************************************
`define LSC_LANES             8
`define LSC_LANE_BITS         3
`define LSC_STAT_RESET        8'h00
`define LSC_UNMAPPED_DATA     8'h00
`define LSC_ACC_RESET         8'h00
`define LSC_BUF_WIDTH         12

// ***********************************************************
// serial frame layout: 16 instruction bits, then 8 data bits
// ***********************************************************
`define LSC_RW_BIT            14
`define LSC_INSTR_LAST        5'h0F
`define LSC_FRAME_BITS        5'h18
`define LSC_CNT_ONE           5'h01
`define LSC_CNT_ZERO          5'h00

`endif

// [core/lsc_pkg.sv]
package lsc_pkg;

  typedef logic [7:0] lsc_lane_vec_t;

  typedef enum logic [1:0] {
    LSC_SPI_IDLE  = 2'b00,
    LSC_SPI_INSTR = 2'b01,
    LSC_SPI_DATA  = 2'b10
  } lsc_spi_state_t;

endpackage

// [core/lsc_pair_buffer.sv]
`timescale 1ns/10ps
`include "lsc_defs.svh"

// ***********************************************************
// two-entry buffer, registered flags on both sides
// ***********************************************************
module lsc_pair_buffer (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        in_valid,
  output logic                             in_ready,
  input  wire logic [`LSC_BUF_WIDTH-1:0]   in_data,
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic [`LSC_BUF_WIDTH-1:0]        out_data
);
  logic [1:0]                 count;
  logic [1:0]                 next_count;
  logic [`LSC_BUF_WIDTH-1:0]  tail;
  wire                        push;
  wire                        pop;
  wire                        load_head;
  wire                        load_tail;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // head takes the input when empty or when it drains with one held
  assign load_head = push & ((count == 2'h0) | ((count == 2'h1) & pop));
  assign load_tail = push & (count == 2'h1) & ~pop;
  assign next_count = (push & ~pop) ? count + 2'h1 :
                      (pop & ~push) ? count - 2'h1 : count;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count     <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= (next_count != 2'h2);
      out_valid <= (next_count != 2'h0);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_data <= {`LSC_BUF_WIDTH{1'b0}};
      tail     <= {`LSC_BUF_WIDTH{1'b0}};
    end else begin
      if (load_head) begin
        out_data <= in_data;
      end else if (pop & (count == 2'h2)) begin
        out_data <= tail;
      end
      if (load_tail) begin
        tail <= in_data;
      end
    end
  end
endmodule

// [testbench/lsc_status_sva.sv]
`timescale 1ns/10ps
// ****
// status checker
// ****
module lsc_status_sva (
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  input wire logic                   skip_initial_alignment,
  input wire lsc_pkg::lsc_lane_vec_t symbol_lock_in,
  input wire lsc_pkg::lsc_lane_vec_t frame_align_in,
  input wire lsc_pkg::lsc_lane_vec_t init_align_in,
  input wire logic                   cfg_valid,
  input wire logic                   cfg_ready,
  input wire lsc_pkg::lsc_lane_vec_t symbol_lock_status,
  input wire lsc_pkg::lsc_lane_vec_t frame_align_status,
  input wire lsc_pkg::lsc_lane_vec_t lane_checksum_ok,
  input wire lsc_pkg::lsc_lane_vec_t initial_lane_align_status
);
  import lsc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_frame;
    !$past(sys_rst) |-> frame_align_status == $past(frame_align_in);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame status not a copy of its input");
  property p_lock;
    !$past(sys_rst) |-> symbol_lock_status == $past(symbol_lock_in);
  endproperty
  a_lock: assert property (p_lock)
    else $error("symbol lock status not a copy of its input");
  property p_init;
    !$past(sys_rst) |-> initial_lane_align_status == $past(init_align_in);
  endproperty
  a_init: assert property (p_init)
    else $error("initial alignment status not a copy of its input");
  property p_rst;
    $fell(sys_rst) |-> {symbol_lock_status, frame_align_status,
                        lane_checksum_ok, initial_lane_align_status} == 32'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("status not zero after reset");
  property p_clr;
    !$past(sys_rst) |-> (lane_checksum_ok & ~$past(symbol_lock_in)) == 8'h00;
  endproperty
  a_clr: assert property (p_clr)
    else $error("checksum bit set on an unlocked lane");
  property p_frz;
    !$past(sys_rst) && $past(skip_initial_alignment) &&
      $past(symbol_lock_in) == 8'hFF |-> $stable(lane_checksum_ok);
  endproperty
  a_frz: assert property (p_frz)
    else $error("checksum changed while alignment skipped");
  property p_idle;
    (!cfg_valid && symbol_lock_in == 8'hFF) [*5] |=> $stable(lane_checksum_ok);
  endproperty
  a_idle: assert property (p_idle)
    else $error("checksum changed with no octets");
  cover property (cfg_valid && !cfg_ready);
  cover property ($rose(lane_checksum_ok[0]));
  cover property ($fell(lane_checksum_ok[0]));
endmodule
bind lsc_status lsc_status_sva u_sva (.mclk(mclk), .sys_rst(sys_rst),
  .skip_initial_alignment(skip_initial_alignment),
  .symbol_lock_in(symbol_lock_in), .frame_align_in(frame_align_in),
  .init_align_in(init_align_in), .cfg_valid(cfg_valid),
  .cfg_ready(cfg_ready), .symbol_lock_status(symbol_lock_status),
  .frame_align_status(frame_align_status),
  .lane_checksum_ok(lane_checksum_ok),
  .initial_lane_align_status(initial_lane_align_status));

// [testbench/lsc_cfg_source.sv]
`timescale 1ns/10ps
// ****
// config octet source
// ****
module lsc_cfg_source (
  input  wire logic       mclk,
  input  wire logic       cfg_ready,
  output logic            cfg_valid,
  output logic [2:0]      cfg_lane,
  output logic [7:0]      cfg_data,
  output logic            cfg_last
);
  initial begin
    cfg_valid = 1'b0;
    cfg_lane = 3'h0;
    cfg_data = 8'h00;
    cfg_last = 1'b0;
  end
  // octet held until ready is seen at a rising edge
  // a stuck ready hangs here until the bench watchdog ends the run
  task automatic send(input logic [2:0] l, input logic [7:0] d,
                      input logic f);
    @(negedge mclk);
    cfg_valid <= 1'b1;
    cfg_lane <= l;
    cfg_data <= d;
    cfg_last <= f;
    do begin
      @(posedge mclk);
    end while (cfg_ready !== 1'b1);
  endtask
  // released lines toggle so nothing leans on a stale octet
  task automatic idle();
    @(negedge mclk);
    cfg_valid <= 1'b0;
    cfg_lane <= ~cfg_lane;
    cfg_data <= ~cfg_data;
    cfg_last <= ~cfg_last;
  endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`include "lsc_defs.svh"
module tb_top;
  import lsc_pkg::*;
  logic          mclk, sys_rst, spi_sclk, spi_cs_n, host_d;
  logic          spi_sdio_out, spi_sdio_oe, skip_initial_alignment;
  logic          cfg_valid, cfg_ready, cfg_last;
  logic [2:0]    cfg_lane;
  logic [7:0]    cfg_data;
  lsc_lane_vec_t symbol_lock_in, frame_align_in, init_align_in, exp_ok;
  lsc_lane_vec_t symbol_lock_status, frame_align_status;
  lsc_lane_vec_t lane_checksum_ok, initial_lane_align_status;
  int            failures, checks_done;
  wire           sdio = spi_sdio_oe ? spi_sdio_out : host_d;
  lsc_status DUT (.mclk(mclk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdio_in(sdio), .spi_sdio_out(spi_sdio_out),
    .spi_sdio_oe(spi_sdio_oe),
    .skip_initial_alignment(skip_initial_alignment),
    .symbol_lock_in(symbol_lock_in), .frame_align_in(frame_align_in),
    .init_align_in(init_align_in), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .cfg_lane(cfg_lane), .cfg_data(cfg_data),
    .cfg_last(cfg_last), .symbol_lock_status(symbol_lock_status),
    .frame_align_status(frame_align_status),
    .lane_checksum_ok(lane_checksum_ok),
    .initial_lane_align_status(initial_lane_align_status));
  lsc_cfg_source src (.mclk(mclk), .cfg_ready(cfg_ready),
    .cfg_valid(cfg_valid), .cfg_lane(cfg_lane), .cfg_data(cfg_data),
    .cfg_last(cfg_last));
  always #12.5 mclk = ~mclk;
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // one byte per frame; sclk phases of 5 cycles keep clear of the sync
  task automatic xfer(input logic w, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] v);
    logic [23:0] f;
    f = {~w, a, d};
    v = 8'h00;
    @(negedge mclk);
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      host_d = f[i];
      repeat (5) @(negedge mclk);
      spi_sclk = 1'b1;
      if (i < 8) v[i] = sdio;
      repeat (5) @(negedge mclk);
      spi_sclk = 1'b0;
    end
    repeat (5) @(negedge mclk);
    spi_cs_n = 1'b1;
    repeat (5) @(negedge mclk);
  endtask
  task automatic frame(input int l, input bit good);
    logic [7:0] s, d;
    s = 8'h00;
    repeat (3) begin
      d = $urandom;
      s += d;
      src.send(l[2:0], d, 1'b0);
      if ($urandom_range(3) == 0) src.idle();
    end
    src.send(l[2:0], good ? s : s + 8'h01, 1'b1);
    if (!skip_initial_alignment && symbol_lock_in[l]) exp_ok[l] = good;
  endtask
  task automatic sums(input string n);
    logic [7:0] v;
    src.idle();
    repeat (8) @(negedge mclk);
    xfer(1'b0, `LSC_ADDR_CFG_SUM_OK, 8'h5A, v);
    chk(n, exp_ok, v);
    chk(n, exp_ok, lane_checksum_ok);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    #(25 * 40000);
    failures++;
    end_sim();
  end
  initial begin
    logic [7:0] v;
    {mclk, spi_sclk, host_d, skip_initial_alignment} = 4'h0;
    {sys_rst, spi_cs_n} = 2'b11;
    {symbol_lock_in, frame_align_in, init_align_in, exp_ok} = 32'h0;
    failures = 0;
    checks_done = 0;
    void'($urandom(23));
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    // 0x474 is unmapped and reads zero as well
    for (int a = 0; a < 5; a++) begin
      xfer(1'b0, `LSC_ADDR_SYMBOL_LOCK + a[14:0], 8'h5A, v);
      chk("reset read", 8'h00, v);
    end
    for (int r = 0; r < 3; r++) begin
      @(negedge mclk);
      symbol_lock_in = $urandom;
      frame_align_in = $urandom;
      init_align_in = $urandom;
      xfer(1'b0, `LSC_ADDR_SYMBOL_LOCK, 8'h5A, v);
      chk("symbol lock", symbol_lock_in, v);
      xfer(1'b0, `LSC_ADDR_FRAME_ALIGN, 8'h5A, v);
      chk("frame align", frame_align_in, v);
      xfer(1'b0, `LSC_ADDR_INIT_ALIGN, 8'h5A, v);
      chk("init align", init_align_in, v);
    end
    @(negedge mclk);
    symbol_lock_in = 8'hFF;
    for (int l = 0; l < 8; l++) frame(l, l % 3 != 1);
    sums("checksum");
    // frame bits are not judged while skipped
    skip_initial_alignment = 1'b1;
    for (int l = 1; l < 8; l += 3) frame(l, 1'b1);
    sums("checksum skipped");
    skip_initial_alignment = 1'b0;
    xfer(1'b1, `LSC_ADDR_CFG_SUM_OK, 8'hFF, v);
    sums("checksum after write");
    symbol_lock_in[0] = 1'b0;
    exp_ok[0] = 1'b0;
    frame(0, 1'b1);
    sums("lock lost");
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    exp_ok = 8'h00;
    sums("second reset");
    frame(3, 1'b1);
    sums("after reset");
    end_sim();
  end
endmodule
